// >>> hw/tap_event_cfg.v
// tap event configuration, source register, thresholds and detection.
// assumes signed 12-bit axis samples on clk, held valid between odr ticks,
// and an Avalon-MM master with byte addresses.
`timescale 1ns/1ns
`default_nettype none
// offsets, field positions and timing counts
`include "tap_regs.vh"

module tap_event_cfg #(
	parameter ODR_CYCLES = `TAP_ODR_CYCLES
) (
	input  wire        clk,
	input  wire        rst,
	input  wire [9:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire [11:0] x_accel,
	input  wire [11:0] y_accel,
	input  wire [11:0] z_accel,
	output reg         irq,
	output reg         odr_tick
);

	// detector states, one-hot
	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_PULSE = 5'h02;
	localparam [4:0] ST_LAT   = 5'h04;
	localparam [4:0] ST_WAIT  = 5'h08;
	localparam [4:0] ST_PULS2 = 5'h10;

	// registers
	reg  [7:0]  tap_config;
	reg  [7:0]  tap_source;
	reg  [6:0]  x_tap_level;
	reg  [6:0]  y_tap_level;
	reg  [6:0]  z_tap_level;
	reg  [7:0]  tap_latency_time;
	reg  [7:0]  tap_ctrl;
	reg  [1:0]  irq_status;
	reg  [1:0]  irq_mask;
	reg  [31:0] odr_count;

	wire        double_tap_abort;
	wire        event_latch_enable;
	wire        low_noise;
	wire [1:0]  fs_sel;
	wire [2:0]  single_en;
	wire [2:0]  double_en;
	wire [7:0]  reg_index;
	wire        addr_ok;
	wire        wr_take;
	wire        rd_take;
	wire [35:0] accel_all;
	wire [20:0] level_all;
	wire [2:0]  ev_single;
	wire [2:0]  ev_double;
	wire [2:0]  ev_sign;
	wire [2:0]  ev_any;
	wire        src_read;

	reg  [7:0]  next_source;
	reg  [7:0]  rd_value;

	assign double_tap_abort   = tap_config[`TAP_CFG_ABORT];
	assign event_latch_enable = tap_config[`TAP_CFG_LATCH];
	assign low_noise          = tap_ctrl[`TAP_CTRL_LNOISE];
	assign fs_sel             = tap_ctrl[`TAP_CTRL_FS_LSB +: 2];
	// enables interleave single at even, double at odd bits
	assign single_en = {tap_config[4], tap_config[2], tap_config[0]};
	assign double_en = {tap_config[5], tap_config[3], tap_config[1]};
	assign accel_all = {z_accel, y_accel, x_accel};
	assign level_all = {z_tap_level, y_tap_level, x_tap_level};

	// register hit: index matches and the byte offset is word aligned
	function tap_hit;
		input [9:0] addr;
		input [7:0] idx;
		begin
			tap_hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
		end
	endfunction

	// bus decoding; the low two address bits must be zero
	assign reg_index = avs_address[9:2];
	assign addr_ok   = (avs_address[1:0] == 2'h0);
	assign wr_take   = avs_write & ~avs_waitrequest & addr_ok;
	assign rd_take   = avs_read & ~avs_waitrequest & addr_ok;
	assign src_read  = rd_take & tap_hit(avs_address, `TAP_IDX_SOURCE);

	// magnitude of a 12-bit sample rescaled to 1/16 g counts; one sample
	// count is 1/1024 g at 2g, 1/512 g at 4g and 1/256 g at 8g full scale
	function [6:0] tap_mag;
		input [11:0] s;
		input [1:0]  fs;
		reg   [11:0] m;
		reg   [11:0] q;
		begin
			m = s[11] ? (~s + 12'h001) : s;
			// thresholds stay on the 8g scale whatever the full scale
			if (fs == 2'h0) begin
				q = m >> 6;
			end else if (fs == 2'h1) begin
				q = m >> 5;
			end else begin
				q = m >> 4;
			end
			// only -2048 at 8g reaches 128; clip it to the top code
			tap_mag = (q > 12'h07F) ? 7'h7F : q[6:0];
		end
	endfunction

	// threshold actually in force; low noise tops out at 4g
	function [6:0] tap_thr;
		input [6:0] lvl;
		input       ln;
		begin
			if (ln && (lvl > `TAP_THR_LN_MAX)) begin
				tap_thr = `TAP_THR_LN_MAX;
			end else begin
				tap_thr = lvl;
			end
		end
	endfunction

	// output data rate divider; detection advances only on its pulse
	// a 32-bit count covers the slowest rates without a prescaler
	always @(posedge clk) begin
		if (rst) begin
			odr_count <= 32'h00000000;
			odr_tick  <= 1'b0;
		end else if (odr_count >= ODR_CYCLES - 1) begin
			odr_count <= 32'h00000000;
			odr_tick  <= 1'b1;
		end else begin
			odr_count <= odr_count + 32'h00000001;
			odr_tick  <= 1'b0;
		end
	end

	// per-axis pulse detector
	genvar a;
	generate
		for (a = 0; a < 3; a = a + 1) begin : g_axis
			reg  [4:0] state;
			reg  [7:0] lat_cnt;
			reg  [7:0] win_cnt;
			reg        sign;
			reg        abort_hit;
			reg        in_lat_pulse;
			reg        ev_s;
			reg        ev_d;
			wire [11:0] smp;
			wire        above;
			// threshold compare at 0.063g per count, 8g range
			assign smp   = accel_all[a*12 +: 12];
			assign above = tap_mag(smp, fs_sel) >
				tap_thr(level_all[a*7 +: 7], low_noise);
			assign ev_single[a] = ev_s;
			assign ev_double[a] = ev_d;
			assign ev_sign[a]   = sign;

			always @(posedge clk) begin
				if (rst) begin
					state        <= ST_IDLE;
					lat_cnt      <= 8'h00;
					win_cnt      <= 8'h00;
					sign         <= 1'b0;
					abort_hit    <= 1'b0;
					in_lat_pulse <= 1'b0;
					ev_s         <= 1'b0;
					ev_d         <= 1'b0;
				end else begin
					ev_s <= 1'b0;
					ev_d <= 1'b0;
					if (odr_tick) begin
						case (state)
						ST_IDLE: begin
							// the sign is kept from the first tick above level
							if (above) begin
								state <= ST_PULSE;
								sign  <= smp[11];
							end
						end
						ST_PULSE: begin
							if (!above) begin
								// first pulse over: report single, start latency
								ev_s         <= single_en[a];
								state        <= ST_LAT;
								lat_cnt      <= tap_latency_time;
								abort_hit    <= 1'b0;
								in_lat_pulse <= 1'b0;
							end
						end
						ST_LAT: begin
							// pulses here never become events
							if (above && !in_lat_pulse) begin
								in_lat_pulse <= 1'b1;
							end else if (!above && in_lat_pulse) begin
								in_lat_pulse <= 1'b0;
								if (double_tap_abort) begin
									abort_hit <= 1'b1;
								end
							end
							// a latency pulse ending on the last tick is too late to abort
							if (lat_cnt != 8'h00) begin
								lat_cnt <= lat_cnt - 8'h01;
							end else if (abort_hit || !double_en[a]) begin
								state <= ST_IDLE;
							end else begin
								// abort clear: a latency pulse changes nothing
								state   <= ST_WAIT;
								win_cnt <= tap_latency_time;
							end
						end
						ST_WAIT: begin
							// a pulse still high from latency must fall first
							if (above && !in_lat_pulse) begin
								state <= ST_PULS2;
							end else if (!above) begin
								in_lat_pulse <= 1'b0;
								if (win_cnt == 8'h00) begin
									state <= ST_IDLE;
								end else begin
									win_cnt <= win_cnt - 8'h01;
								end
							end else if (win_cnt == 8'h00) begin
								state <= ST_IDLE;
							end else begin
								win_cnt <= win_cnt - 8'h01;
							end
						end
						ST_PULS2: begin
							// the second tap is reported when it falls
							if (!above) begin
								ev_d  <= double_en[a];
								state <= ST_IDLE;
							end
						end
						default: begin
							state <= ST_IDLE;
						end
						endcase
					end
				end
			end
		end
	endgenerate

	assign ev_any = ev_single | ev_double;

	// next source value; a new event wins over a clearing read
	// with the latch off the newest event replaces the whole record
	always @* begin
		next_source = tap_source;
		if (src_read) begin
			next_source = 8'h00;
		end
		if (|ev_any) begin
			if (event_latch_enable && tap_source[`TAP_SRC_ACTIVE] && !src_read) begin
				next_source = tap_source;
			end else begin
				next_source[`TAP_SRC_ACTIVE] = 1'b1;
				next_source[`TAP_SRC_SEEN_LSB +: 3] = ev_any;
				next_source[`TAP_SRC_DOUBLE] = |ev_double;
				next_source[`TAP_SRC_SIGN_LSB +: 3] = ev_sign & ev_any;
			end
		end
	end

	// source register
	always @(posedge clk) begin
		if (rst) begin
			tap_source <= 8'h00;
		end else begin
			tap_source <= next_source;
		end
	end

	// software-written registers, taken at the edge with waitrequest low
	// the latency count also sizes the second-tap window, to save a register
	always @(posedge clk) begin
		if (rst) begin
			tap_config       <= `TAP_CFG_RESET;
			x_tap_level      <= `TAP_THR_RESET;
			y_tap_level      <= `TAP_THR_RESET;
			z_tap_level      <= `TAP_THR_RESET;
			tap_latency_time <= `TAP_LAT_RESET;
			tap_ctrl         <= `TAP_CTRL_RESET;
			irq_mask         <= 2'h0;
		end else if (wr_take) begin
			if (reg_index == `TAP_IDX_CONFIG) begin
				tap_config <= avs_writedata[7:0];
			end else if (reg_index == `TAP_IDX_THR_X) begin
				x_tap_level <= avs_writedata[6:0];
			end else if (reg_index == `TAP_IDX_THR_Y) begin
				y_tap_level <= avs_writedata[6:0];
			end else if (reg_index == `TAP_IDX_THR_Z) begin
				z_tap_level <= avs_writedata[6:0];
			end else if (reg_index == `TAP_IDX_LATENCY) begin
				tap_latency_time <= avs_writedata[7:0];
			end else if (reg_index == `TAP_IDX_CTRL) begin
				tap_ctrl <= {5'h00, avs_writedata[2:0]};
			end else if (reg_index == `TAP_IDX_IRQ_MASK) begin
				irq_mask <= avs_writedata[1:0];
			end
		end
	end

	// sticky interrupt status: write one clears, source read clears,
	// and an event in the same cycle keeps its bit set
	always @(posedge clk) begin
		if (rst) begin
			irq_status <= 2'h0;
			irq        <= 1'b0;
		end else begin
			if (src_read) begin
				irq_status <= {|ev_double, |ev_single};
			end else if (wr_take && tap_hit(avs_address, `TAP_IDX_IRQ_STAT)) begin
				irq_status <= (irq_status & ~avs_writedata[1:0]) |
					{|ev_double, |ev_single};
			end else begin
				irq_status <= irq_status | {|ev_double, |ev_single};
			end
			// registered line, so it follows the status one cycle late
			irq <= |(irq_status & irq_mask);
		end
	end

	// read multiplexer; unmapped indices read zero
	// misaligned offsets read zero rather than alias a register
	always @* begin
		rd_value = 8'h00;
		if (reg_index == `TAP_IDX_CONFIG) begin
			rd_value = tap_config;
		end else if (reg_index == `TAP_IDX_SOURCE) begin
			rd_value = tap_source;
		end else if (reg_index == `TAP_IDX_THR_X) begin
			rd_value = {1'b0, x_tap_level};
		end else if (reg_index == `TAP_IDX_THR_Y) begin
			rd_value = {1'b0, y_tap_level};
		end else if (reg_index == `TAP_IDX_THR_Z) begin
			rd_value = {1'b0, z_tap_level};
		end else if (reg_index == `TAP_IDX_LATENCY) begin
			rd_value = tap_latency_time;
		end else if (reg_index == `TAP_IDX_CTRL) begin
			rd_value = tap_ctrl;
		end else if (reg_index == `TAP_IDX_IRQ_STAT) begin
			rd_value = {6'h00, irq_status};
		end else if (reg_index == `TAP_IDX_IRQ_MASK) begin
			rd_value = {6'h00, irq_mask};
		end
		if (!addr_ok) begin
			rd_value = 8'h00;
		end
	end

	// one wait cycle per access; read data captured with the answer
	// idling high costs a cycle but keeps read data straight from a flop
	always @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= {24'h000000, rd_value};
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// >>> hw/tap_regs.vh
// register map, field positions, reset values and timing counts of the
// tap event configuration and status block.
// assumes an including file that uses these names and nothing else.
// Notes on behaviour
// - abort clear: latency pulses keep double detection
// - abort set: pulse inside latency suspends double
// - config bit 6 latches flags until read
// - six per-axis single/double enables, reset zero
// - event shown only if axis and type enabled
// - source bit 7 marks any event
// - source bits 6..4 mark Z,Y,X events
// - source bit 3: single zero, double one
// - source bits 2..0: Z,Y,X sign, one negative
// - latched and active: other source bits frozen
// - source read clears it and the interrupt
// - three 7-bit thresholds, bit 7 reads zero
// - threshold 0.063g per count over 8g
// - low noise caps reachable threshold at 4g
// - detection starts when magnitude exceeds threshold
// - latency follows first pulse, pulses ignored
`ifndef TAP_REGS_VH
`define TAP_REGS_VH

// register indices; byte address is four times the index
`define TAP_IDX_CONFIG    8'h21
`define TAP_IDX_SOURCE    8'h22
`define TAP_IDX_THR_X     8'h23
`define TAP_IDX_THR_Y     8'h24
`define TAP_IDX_THR_Z     8'h25
`define TAP_IDX_LATENCY   8'h27
`define TAP_IDX_CTRL      8'h2A
`define TAP_IDX_IRQ_STAT  8'h30
`define TAP_IDX_IRQ_MASK  8'h31

// config fields
`define TAP_CFG_ABORT     7
`define TAP_CFG_LATCH     6
`define TAP_CFG_RESET     8'h00

// source fields
`define TAP_SRC_ACTIVE    7
`define TAP_SRC_SEEN_LSB  4
`define TAP_SRC_DOUBLE    3
`define TAP_SRC_SIGN_LSB  0

// control fields: low noise and full-scale select
`define TAP_CTRL_LNOISE   0
`define TAP_CTRL_FS_LSB   1
`define TAP_CTRL_RESET    8'h00

// interrupt status bits
`define TAP_IRQ_SINGLE    0
`define TAP_IRQ_DOUBLE    1

`define TAP_THR_RESET     7'h00
`define TAP_LAT_RESET     8'h00
// 4g at 0.0625g per count
`define TAP_THR_LN_MAX    7'h40

// output data rate timing
`define TAP_CLK_PERIOD_NS 4
`define TAP_ODR_PERIOD_NS 1250000
`define TAP_ODR_CYCLES    (`TAP_ODR_PERIOD_NS / `TAP_CLK_PERIOD_NS)

`endif

// >>> verif/tap_event_cfg_props.sv
// checker for the tap block: bus answers, source contents and the irq line
// assumes byte addresses and the block's one-cycle bus answer
`timescale 1ns/1ns
`default_nettype none
module tap_event_cfg_props #(
	parameter ODR_CYCLES = 8
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [9:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        irq,
	input wire logic        odr_tick
);
	// answered accesses and a copy of the last config write
	wire logic  ack = !avs_waitrequest && (avs_read || avs_write);
	wire logic  src_rd = ack && avs_read && avs_address == 10'h088;
	logic [7:0] cfg_sh;
	always @(posedge clk) begin
		if (rst)
			cfg_sh <= 8'h00;
		else if (ack && avs_write && avs_address == 10'h084)
			cfg_sh <= avs_writedata[7:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_src_reread;
		src_rd ##3 src_rd;
	endsequence
	sequence s_irq_gone;
		##2 !irq;
	endsequence
	property p_thr_msb;
		ack && avs_read && avs_address inside {10'h08C, 10'h090, 10'h094} |-> !avs_readdata[7];
	endproperty
	a_thr_msb: assert property (p_thr_msb)
		else $error("threshold bit 7 read as one");
	property p_cfg_back;
		ack && avs_read && avs_address == 10'h084 |-> avs_readdata[7:0] == cfg_sh;
	endproperty
	a_cfg_back: assert property (p_cfg_back)
		else $error("config read differs from last write");
	property p_ea_axis;
		src_rd |-> avs_readdata[7] == |avs_readdata[6:4];
	endproperty
	a_ea_axis: assert property (p_ea_axis)
		else $error("event flag and axis bits disagree");
	property p_ea_rest;
		src_rd && |avs_readdata[3:0] |-> avs_readdata[7];
	endproperty
	a_ea_rest: assert property (p_ea_rest)
		else $error("type or sign set without event flag");
	property p_axis_en;
		src_rd |-> (!avs_readdata[4] || |cfg_sh[1:0]) && (!avs_readdata[5] || |cfg_sh[3:2])
			&& (!avs_readdata[6] || |cfg_sh[5:4]);
	endproperty
	a_axis_en: assert property (p_axis_en)
		else $error("event on a disabled axis");
	property p_dbl_en;
		src_rd && avs_readdata[3] |-> cfg_sh[5] || cfg_sh[3] || cfg_sh[1];
	endproperty
	a_dbl_en: assert property (p_dbl_en)
		else $error("double tap shown while disabled");
	// a source read drops irq unless an event lands around it
	property p_src_irq;
		src_rd && !odr_tick && !$past(odr_tick) |-> s_irq_gone;
	endproperty
	a_src_irq: assert property (p_src_irq)
		else $error("irq held after source read");
	property p_src_reread;
		s_src_reread |-> $past(odr_tick, 3) || $past(odr_tick, 4) || avs_readdata[7:0] == 8'h00;
	endproperty
	a_src_reread: assert property (p_src_reread)
		else $error("source not cleared by read");
endmodule
bind tap_event_cfg tap_event_cfg_props #(.ODR_CYCLES(ODR_CYCLES)) u_props (.clk(clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq), .odr_tick(odr_tick));
`default_nettype wire

// >>> verif/tap_host.sv
// host model: an Avalon-MM master reading and writing the tap registers
// assumes it is called right after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module tap_host (
	input  wire logic        clk,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output var  logic [9:0]  avs_address,
	output var  logic        avs_read,
	output var  logic        avs_write,
	output var  logic [31:0] avs_writedata,
	output var  logic        hang
);
	initial begin
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		hang = 1'b0;
	end
	// one access; an edge passes first so a release never meets a raise
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			hang <= 1'b1;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verif/tb_tap_event_cfg.sv
// self-checking bench for the tap block through its register bus
// assumes the host model in tap_host.sv and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_tap_event_cfg;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] x_accel = 12'h000;
	logic [11:0] y_accel = 12'h000;
	logic [11:0] z_accel = 12'h000;
	wire logic [9:0]  avs_address;
	wire logic        avs_read, avs_write, avs_waitrequest, irq, odr_tick, hang;
	wire logic [31:0] avs_writedata, avs_readdata;
	int num_errors = 0;
	int compares = 0;
	always #2 clk = ~clk;
	// short output data rate keeps detection runs brief
	tap_event_cfg #(.ODR_CYCLES(8)) dut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .x_accel(x_accel),
		.y_accel(y_accel), .z_accel(z_accel), .irq(irq), .odr_tick(odr_tick));
	tap_host host (.clk(clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .hang(hang));
	task automatic close_out;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge hang) begin
		num_errors++;
		close_out();
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] q;
		host.xfer(1'b1, a, {24'h0, d}, q);
	endtask
	task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] e);
		logic [31:0] q;
		host.xfer(1'b0, a, 32'h0, q);
		chk(nm, {24'h0, e}, q);
	endtask
	// wait for k detection steps, bounded
	task automatic ticks(input int k);
		int n;
		repeat (k) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (odr_tick !== 1'b1 && n < 40);
			if (n >= 40) begin
				chk("odr tick", 32'h1, 32'h0);
				close_out();
			end
		end
	endtask
	// one sample above level, then one below
	task automatic tap(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c);
		x_accel <= a;
		y_accel <= b;
		z_accel <= c;
		ticks(1);
		x_accel <= 12'h000;
		y_accel <= 12'h000;
		z_accel <= 12'h000;
		ticks(1);
	endtask
	// let the event settle, then read it, read again and see irq drop
	task automatic expect_src(input logic [7:0] e);
		ticks(1);
		repeat (4) @(posedge clk);
		chk("irq", {31'h0, e != 8'h00}, {31'h0, irq});
		rd("source", 10'h088, e);
		rd("source again", 10'h088, 8'h00);
		chk("irq after read", 32'h0, {31'h0, irq});
		ticks(12);
	endtask
	task automatic tap_case(input logic [7:0] cfg, input logic [6:0] thr,
		input logic [11:0] a, input logic [11:0] b, input logic [11:0] c, input logic [7:0] e);
		wr(10'h084, cfg);
		for (int i = 0; i < 3; i++)
			wr(10'h08C + 10'(4 * i), {1'b0, thr});
		tap(a, b, c);
		expect_src(e);
	endtask
	// first tap, a short pulse inside latency, then one inside the window
	task automatic dbl_case(input logic [7:0] cfg, input logic [7:0] e);
		wr(10'h084, cfg);
		tap(12'h200, 12'h000, 12'h000);
		ticks(1);
		tap(12'h200, 12'h000, 12'h000);
		ticks(2);
		tap(12'h200, 12'h000, 12'h000);
		expect_src(e);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++)
			rd("reset value", 10'h084 + 10'(4 * i), 8'h00);
		wr(10'h09C, 8'h04);
		wr(10'h0C4, 8'h03);
		wr(10'h08C, 8'hFF);
		rd("threshold x", 10'h08C, 8'h7F);
		wr(10'h02C, 8'h5A);
		rd("unmapped", 10'h02C, 8'h00);
		tap_case(8'h01, 7'h04, 12'h200, 12'h000, 12'h000, 8'h90);
		tap_case(8'h02, 7'h04, 12'h200, 12'h000, 12'h000, 8'h00);
		tap_case(8'h10, 7'h04, 12'h200, 12'h000, 12'h000, 8'h00);
		tap_case(8'h01, 7'h08, 12'h200, 12'h000, 12'h000, 8'h00);
		tap_case(8'h04, 7'h04, 12'h000, 12'hE00, 12'h000, 8'hA2);
		tap_case(8'h10, 7'h07, 12'h000, 12'h000, 12'h200, 8'hC0);
		dbl_case(8'h03, 8'h98);
		dbl_case(8'h83, 8'h90);
		wr(10'h084, 8'h54);
		tap(12'h000, 12'hE00, 12'h000);
		ticks(1);
		repeat (4) @(posedge clk);
		rd("irq status", 10'h0C0, 8'h01);
		wr(10'h0C4, 8'h00);
		repeat (3) @(posedge clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(10'h0C4, 8'h03);
		repeat (3) @(posedge clk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(10'h0C0, 8'h01);
		repeat (3) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		tap(12'h000, 12'h000, 12'h200);
		expect_src(8'hA2);
		// 8g scale and the low noise cap, x axis only
		wr(10'h0A8, 8'h04);
		rd("ctrl", 10'h0A8, 8'h04);
		tap_case(8'h01, 7'h20, 12'h210, 12'h000, 12'h000, 8'h90);
		tap_case(8'h01, 7'h20, 12'h200, 12'h000, 12'h000, 8'h00);
		tap_case(8'h01, 7'h7F, 12'h500, 12'h000, 12'h000, 8'h00);
		wr(10'h0A8, 8'h05);
		tap_case(8'h01, 7'h7F, 12'h500, 12'h000, 12'h000, 8'h90);
		close_out();
	end
endmodule
`default_nettype wire
